/* File: design/kme_keypad_menu_editor.sv */
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - Back held two seconds opens menu
// - Password entry shows only edited digit
// - Right password opens menu, else error
// - All-zero password skips the check
// - Enter descends submenu or starts editing
// - Back climbs one level or to measurement
// - One idle minute in menu exits
// - Up/down quick-views thresholds, five second timeout
// - Quick-view edit needs free access
// - Confirmed quick edit shows new value briefly
// - Digit mode: up/down digit, enter moves
// - Long enter prompts, short enter stores
// - Back at prompt discards the edit
// - Held up accelerates slide increase
// - Down slows increase, momentary or held
// - Decrease mirrors increase behaviour
// - List edit steps through one option
// - List: enter prompts, enter stores, back cancels
module kme_keypad_menu_editor import kme_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        BTN_UP,
  input  wire logic        BTN_DOWN,
  input  wire logic        BTN_ENTER,
  input  wire logic        BTN_BACK,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output kme_disp_t        DISP,
  output logic             NV_WE,
  output logic [2:0]       NV_ADDR,
  output kme_val_t         NV_DATA
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic kme_val_t dig_step(input kme_val_t v, input logic [2:0] d, input logic up);
    kme_val_t   r;
    logic [3:0] x;
    r = v;
    x = v[d*4 +: 4];
    if (up) x = (x == BCD_MAX) ? BCD_ZERO : x + 4'h1;
    else    x = (x == BCD_ZERO) ? BCD_MAX : x - 4'h1;
    r[d*4 +: 4] = x;
    return r;
  endfunction

  function automatic logic [23:0] mag_step(input logic [23:0] m, input logic up);
    logic [23:0] r;
    logic        c;
    r = m;
    c = 1'b1;
    for (int i = 0; i < NDIG; i++) begin
      if (c && up) begin
        c = (r[i*4 +: 4] == BCD_MAX);
        r[i*4 +: 4] = c ? BCD_ZERO : r[i*4 +: 4] + 4'h1;
      end else if (c) begin
        c = (r[i*4 +: 4] == BCD_ZERO);
        r[i*4 +: 4] = c ? BCD_MAX : r[i*4 +: 4] - 4'h1;
      end
    end
    return (up && c) ? m : r;
  endfunction

  // Signed BCD step; zero going down becomes minus one
  function automatic kme_val_t slide_step(input kme_val_t v, input logic up);
    logic [23:0] m;
    m = mag_step(v[23:0], up ^ v[SGN]);
    if (v[23:0] == '0 && !up) return {1'b1, ONE_MAG};
    return {v[SGN] & (m != '0), m};
  endfunction

  function automatic kme_val_t list_max(input logic [2:0] p);
    case (p)
      P_MODE:   return MODE_MAX;
      P_BRIGHT: return BRIGHT_MAX;
      default:  return FLAG_MAX;
    endcase
  endfunction

  function automatic kme_ms_t sat_inc(input kme_ms_t c, input logic en);
    return (en && c != MS_MAX) ? c + 16'd1 : c;
  endfunction

  // ****************************************
  // Millisecond tick and buttons
  // ****************************************
  logic [15:0] tick_cnt;
  logic        tick;
  logic [3:0]  sync1, sync2, stable, long_done;
  logic [3:0]  ev_press, ev_short, ev_long;
  kme_ms_t     deb_cnt [4];
  kme_ms_t     hold_ms [4];
  wire  [3:0]  raw = {BTN_BACK, BTN_ENTER, BTN_DOWN, BTN_UP};
  wire         any_press = |ev_press;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 16'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == 16'(TICK_CYC - 1)) ? '0 : tick_cnt + 16'd1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // Debounce per button, then classify by hold length
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      stable <= '0; long_done <= '0; ev_press <= '0; ev_short <= '0; ev_long <= '0;
      for (int i = 0; i < 4; i++) begin
        deb_cnt[i] <= '0;
        hold_ms[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        ev_press[i] <= 1'b0;
        ev_short[i] <= 1'b0;
        ev_long[i]  <= 1'b0;
        if (sync2[i] == stable[i]) deb_cnt[i] <= '0;
        else if (tick) deb_cnt[i] <= deb_cnt[i] + 16'd1;
        if (sync2[i] != stable[i] && deb_cnt[i] >= DEB_MS) begin
          stable[i]   <= sync2[i];
          deb_cnt[i]  <= '0;
          hold_ms[i]  <= '0;
          long_done[i] <= 1'b0;
          ev_press[i] <= sync2[i];
          ev_short[i] <= !sync2[i] && !long_done[i];
        end else if (stable[i]) begin
          hold_ms[i] <= sat_inc(hold_ms[i], tick);
          if (hold_ms[i] >= LONG_MS && !long_done[i]) begin
            long_done[i] <= 1'b1;
            ev_long[i]   <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Menu state machine
  // ****************************************
  kme_state_t  state, next_state;
  logic        level, next_level, sub, next_sub, from_quick, next_fq, qidx, next_qidx;
  logic [1:0]  item, next_item;
  logic [2:0]  pos, next_pos;
  kme_val_t    work, next_work;
  kme_ms_t     tmr;
  logic        tmr_clr, st_we, slide_hit, slide_up, dir_up;
  kme_val_t    param [NPARAM];
  wire  [2:0]  cur       = from_quick ? {2'b00, qidx} : {sub, item};
  wire         cur_list  = (cur == P_MODE) || (cur >= P_FREE);
  wire         slide_md  = (param[P_EDIT] != PARAM_RST);
  wire         up_dn     = ev_press[B_UP] | ev_press[B_DN];
  wire  [15:0] pass_in   = work[15:0];
  wire         pass_zero = (param[P_PASS][15:0] == '0);
  kme_state_t  ret_state;

  always_comb begin
    next_state = state;   next_level = level; next_sub = sub;   next_item = item;
    next_work  = work;    next_pos   = pos;   next_fq  = from_quick;
    next_qidx  = qidx;    tmr_clr    = 1'b0;  st_we    = 1'b0;
    ret_state  = from_quick ? S_QUICK : S_MENU;
    case (state)
      S_MEAS: begin
        if (ev_long[B_BK]) begin
          next_level = 1'b0;
          next_sub   = 1'b0;
          next_item  = '0;
          next_work  = PARAM_RST;
          next_pos   = '0;
          next_state = pass_zero ? S_MENU : S_PASS;
        end else if (up_dn) begin
          next_state = S_QUICK;
          next_qidx  = 1'b0;
        end
      end
      S_PASS: begin
        if (up_dn) next_work = dig_step(work, PASS_MSD - pos, ev_press[B_UP]);
        if (ev_short[B_EN] && pos == PASS_LAST)
          next_state = (pass_in == param[P_PASS][15:0]) ? S_MENU : S_ERR;
        else if (ev_short[B_EN]) next_pos = pos + 3'd1;
        if (ev_short[B_BK]) next_state = S_MEAS;
      end
      S_ERR: if (tmr >= ERR_MS) next_state = S_MEAS;
      S_MENU: begin
        tmr_clr = any_press;
        if (tmr >= IDLE_MS) next_state = S_MEAS;
        else if (up_dn && !level) next_sub = ~sub;
        else if (up_dn) next_item = ev_press[B_UP] ? item + 2'd1 : item - 2'd1;
        else if (ev_short[B_EN] && !level) begin
          next_level = 1'b1;
          next_item  = '0;
        end else if (ev_short[B_EN]) begin
          next_state = S_EDIT;
          next_work  = param[{sub, item}];
          next_pos   = '0;
          next_fq    = 1'b0;
        end else if (ev_short[B_BK] && level) next_level = 1'b0;
        else if (ev_short[B_BK]) next_state = S_MEAS;
      end
      S_EDIT: begin
        if (cur_list) begin
          if (ev_press[B_UP]) next_work = (work >= list_max(cur)) ? PARAM_RST : work + 25'd1;
          else if (ev_press[B_DN]) next_work = (work == PARAM_RST) ? list_max(cur) : work - 25'd1;
          if (ev_short[B_EN]) next_state = S_CONF;
        end else begin
          if (ev_long[B_EN]) next_state = S_CONF;
          if (slide_md && slide_hit) next_work = slide_step(work, dir_up);
          else if (!slide_md && up_dn && pos == SIGN_POS) next_work[SGN] = ~work[SGN];
          else if (!slide_md && up_dn) next_work = dig_step(work, NUM_MSD - pos, ev_press[B_UP]);
          if (!slide_md && ev_short[B_EN]) next_pos = (pos == SIGN_POS) ? '0 : pos + 3'd1;
        end
        if (ev_short[B_BK]) next_state = ret_state;
      end
      S_CONF: begin
        if (ev_short[B_EN]) begin
          st_we      = 1'b1;
          next_state = from_quick ? S_QNEW : S_MENU;
        end else if (ev_short[B_BK]) next_state = ret_state;
      end
      S_QUICK: begin
        tmr_clr = up_dn;
        if (up_dn) next_qidx = ~qidx;
        else if (tmr >= QUICK_MS) next_state = S_MEAS;
        else if (ev_short[B_EN] && param[P_FREE] != PARAM_RST) begin
          next_state = S_EDIT;
          next_work  = param[{2'b00, qidx}];
          next_pos   = '0;
          next_fq    = 1'b1;
        end
      end
      S_QNEW: begin
        if (up_dn) begin
          next_state = S_QUICK;
          next_qidx  = ~qidx;
        end else if (tmr >= QNEW_MS) next_state = S_MEAS;
      end
      default: next_state = S_MEAS;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= S_MEAS; level <= 1'b0; sub <= 1'b0; item <= '0; from_quick <= 1'b0;
      qidx  <= 1'b0;   pos   <= '0;   work <= PARAM_RST; tmr <= '0;
    end else begin
      state <= next_state; level <= next_level; sub <= next_sub; item <= next_item;
      from_quick <= next_fq; qidx <= next_qidx; pos <= next_pos; work <= next_work;
      tmr <= (tmr_clr || next_state != state) ? '0 : sat_inc(tmr, tick);
    end
  end

  // ****************************************
  // Slide rate control
  // ****************************************
  // Secondary button restarts acceleration, so a tap is a brief slow-down
  kme_ms_t accel_ms, step_ms;
  // A lone button sets direction at once, so the first step follows the new press
  assign dir_up = (stable[B_UP] ^ stable[B_DN]) ? stable[B_UP] : slide_up;
  wire     prim  = dir_up ? stable[B_UP] : stable[B_DN];
  wire     other = dir_up ? stable[B_DN] : stable[B_UP];
  wire kme_ms_t interval = (accel_ms < MID_AFTER_MS) ? SLOW_MS :
                           (accel_ms < FAST_AFTER_MS) ? MID_MS : FAST_MS;
  wire     first = dir_up ? ev_press[B_UP] && !stable[B_DN] : ev_press[B_DN] && !stable[B_UP];
  assign slide_hit = first || (prim && step_ms >= interval);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      slide_up <= 1'b1;
      accel_ms <= '0;
      step_ms  <= '0;
    end else begin
      slide_up <= dir_up;
      accel_ms <= (!prim || other) ? '0 : sat_inc(accel_ms, tick);
      step_ms  <= (!prim || slide_hit) ? '0 : sat_inc(step_ms, tick);
    end
  end

  // ****************************************
  // Stored parameters and display
  // ****************************************
  logic [2:0] psel;
  logic       alt;
  kme_ms_t    alt_ms;
  logic       wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wdat;
  kme_disp_t  next_disp;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < NPARAM; i++) param[i] <= PARAM_RST;
    end else if (st_we) begin
      param[cur] <= work;
    end else if (wr_go && wr_addr == REG_PDATA) begin
      param[psel] <= wdat[24:0];
    end
  end

  always_comb begin
    next_disp = '{mode: DM_VALUE, value: work, digit_en: '1, flash: pos, flash_en: !slide_md};
    case (state)
      S_MEAS:  next_disp = '{mode: DM_MEAS, value: '0, digit_en: '1, flash: '0, flash_en: 1'b0};
      S_PASS:  begin
        next_disp.digit_en = 6'h01 << (PASS_MSD - pos);
        next_disp.flash_en = 1'b1;
      end
      S_ERR:   next_disp.mode = DM_ERROR;
      S_MENU:  next_disp = '{mode: DM_ITEM, value: 25'({level, sub, item}), digit_en: '1,
                             flash: '0, flash_en: 1'b0};
      S_EDIT:  next_disp.flash_en = !slide_md && !cur_list;
      S_CONF:  next_disp.mode = DM_CONFIRM;
      default: next_disp = '{mode: alt ? DM_VALUE : DM_LABEL,
                             value: alt ? param[{2'b00, qidx}] : 25'(qidx),
                             digit_en: '1, flash: '0, flash_en: 1'b0};
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      DISP <= '0; NV_WE <= 1'b0; NV_ADDR <= '0; NV_DATA <= '0; alt <= 1'b0; alt_ms <= '0;
    end else begin
      DISP    <= next_disp;
      NV_WE   <= st_we;
      NV_ADDR <= st_we ? cur : NV_ADDR;
      NV_DATA <= st_we ? work : NV_DATA;
      alt_ms  <= (alt_ms >= ALT_MS || next_state != state) ? '0 : sat_inc(alt_ms, tick);
      alt     <= (next_state != state) ? 1'b0 : alt ^ (alt_ms >= ALT_MS);
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  wire         aw_hs  = AWVALID && AWREADY;
  wire         w_hs   = WVALID && WREADY;
  wire         ar_hs  = ARVALID && ARREADY;
  assign wdat = w_hs ? WDATA : w_q;
  wire  [3:0]  wstrb  = w_hs ? WSTRB : ws_q;
  wire         wr_ok  = (wr_addr == REG_PSEL) || (wr_addr == REG_PDATA) ||
                        (wr_addr == REG_STATUS) || (wr_addr == REG_WORK);
  wire         rd_ok  = (ARADDR == REG_PSEL) || (ARADDR == REG_PDATA) ||
                        (ARADDR == REG_STATUS) || (ARADDR == REG_WORK);
  kme_status_t status;
  wire  [31:0] rd_mux = (ARADDR == REG_STATUS) ? status :
                        (ARADDR == REG_WORK)   ? 32'(work) :
                        (ARADDR == REG_PSEL)   ? 32'(psel) :
                        (ARADDR == REG_PDATA)  ? 32'(param[psel]) : '0;
  assign wr_addr = aw_hs ? AWADDR : aw_q;
  assign wr_go   = (!AWREADY || aw_hs) && (!WREADY || w_hs) && !BVALID && wstrb == STRB_ALL;
  assign status  = '{rsvd: '0, from_quick: from_quick, pos: pos, item: item, sub: sub,
                     level: level, state: state};

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      AWREADY <= 1'b1; WREADY <= 1'b1; BVALID <= 1'b0; BRESP <= RESP_OKAY;
      aw_q <= '0; w_q <= '0; ws_q <= '0; psel <= '0;
    end else begin
      if (aw_hs) begin
        aw_q    <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (w_hs) begin
        w_q    <= WDATA;
        ws_q   <= WSTRB;
        WREADY <= 1'b0;
      end
      if ((!AWREADY || aw_hs) && (!WREADY || w_hs) && !BVALID) begin
        BVALID <= 1'b1;
        BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_go && wr_addr == REG_PSEL) psel <= wdat[2:0];
      end
      if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b1; RVALID <= 1'b0; RDATA <= '0; RRESP <= RESP_OKAY;
    end else if (ar_hs) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_mux;
      RRESP   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_menu_needs_long: assert property ((state == S_MEAS) && !ev_long[B_BK] |=>
    !(state inside {S_MENU, S_PASS})) else $error("menu opened without long back press");
  a_pass_skip: assert property ((state == S_MEAS) && ev_long[B_BK] && pass_zero |=>
    state == S_MENU) else $error("zero password did not open menu");
  a_pass_wrong: assert property ((state == S_PASS) && ev_short[B_EN] && pos == PASS_LAST &&
    pass_in != param[P_PASS][15:0] |=> state == S_ERR ##[1:2] DISP.mode == DM_ERROR)
    else $error("wrong password not rejected");
  a_pass_mask: assert property ((state == S_PASS) ##1 (state == S_PASS) |->
    $onehot(DISP.digit_en)) else $error("password shows more than one digit");
  a_idle_exit: assert property ((state == S_MENU) && $past(state) == S_MENU &&
    tmr < IDLE_MS && !any_press ##1 (state == S_MENU) |-> tmr == $past(tmr) + 16'($past(tick)))
    else $error("menu idle timer misbehaves");
  a_store_conf: assert property ((state == S_CONF) && ev_short[B_EN] |=>
    NV_WE && NV_DATA == $past(work) ##1 !NV_WE) else $error("confirm did not store value");
  a_cancel_keep: assert property ((state == S_CONF) && ev_short[B_BK] && !ev_short[B_EN] |=>
    !NV_WE && state != S_CONF && param[$past(cur)] == $past(param[cur]))
    else $error("cancel changed the stored value");
  a_store_only: assert property (NV_WE |-> $past(state) == S_CONF)
    else $error("store outside the confirm prompt");
  a_free_gate: assert property ((state == S_QUICK) && ev_short[B_EN] &&
    param[P_FREE] == PARAM_RST |=> state != S_EDIT) else $error("edit without free access");
  a_quick_timeout: assert property ((state == S_QUICK) && tmr >= QUICK_MS && !up_dn |=>
    state == S_MEAS) else $error("quick view did not time out");
  a_list_range: assert property ((state == S_EDIT) && cur_list && up_dn |=>
    work <= list_max(cur)) else $error("list option out of range");

  c_menu_entry: cover property ((state == S_MEAS) ##1 (state == S_MENU));
  c_pass_error: cover property ((state == S_PASS) ##1 (state == S_ERR));
  c_quick_store: cover property ((state == S_CONF) && from_quick ##1 (state == S_QNEW));
  c_slide_fast: cover property ((state == S_EDIT) && slide_md && interval == FAST_MS);

endmodule // kme_keypad_menu_editor

/* File: design/kme_pkg.sv */
package kme_pkg;

  // ****************************************
  // Time base
  // ****************************************
  localparam int CLK_HZ      = 10_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  typedef logic [15:0] kme_ms_t;
  localparam kme_ms_t DEB_MS        = 16'd20;
  localparam kme_ms_t LONG_MS       = 16'd2000;
  localparam kme_ms_t QUICK_MS      = 16'd5000;
  localparam kme_ms_t QNEW_MS       = 16'd3000;
  localparam kme_ms_t IDLE_MS       = 16'd60000;
  localparam kme_ms_t ERR_MS        = 16'd1000;
  localparam kme_ms_t ALT_MS        = 16'd1000;
  localparam kme_ms_t SLOW_MS       = 16'd200;
  localparam kme_ms_t MID_MS        = 16'd50;
  localparam kme_ms_t FAST_MS       = 16'd10;
  localparam kme_ms_t MID_AFTER_MS  = 16'd1000;
  localparam kme_ms_t FAST_AFTER_MS = 16'd3000;
  localparam kme_ms_t MS_MAX        = 16'hffff;

  // ****************************************
  // Buttons, values, parameters
  // ****************************************
  localparam int B_UP = 0;
  localparam int B_DN = 1;
  localparam int B_EN = 2;
  localparam int B_BK = 3;

  typedef logic [24:0] kme_val_t;
  localparam int       NDIG     = 6;
  localparam int       SGN      = 24;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  localparam logic [23:0] ONE_MAG = 24'h000001;
  localparam logic [2:0] NUM_MSD  = 3'd5;
  localparam logic [2:0] SIGN_POS = 3'd6;
  localparam logic [2:0] PASS_MSD = 3'd3;
  localparam logic [2:0] PASS_LAST = 3'd3;

  localparam int         NPARAM   = 8;
  localparam logic [2:0] P_THR1   = 3'd0;
  localparam logic [2:0] P_THR2   = 3'd1;
  localparam logic [2:0] P_HYST   = 3'd2;
  localparam logic [2:0] P_MODE   = 3'd3;
  localparam logic [2:0] P_PASS   = 3'd4;
  localparam logic [2:0] P_FREE   = 3'd5;
  localparam logic [2:0] P_EDIT   = 3'd6;
  localparam logic [2:0] P_BRIGHT = 3'd7;
  localparam kme_val_t   MODE_MAX   = 25'd5;
  localparam kme_val_t   FLAG_MAX   = 25'd1;
  localparam kme_val_t   BRIGHT_MAX = 25'd7;
  localparam kme_val_t   PARAM_RST  = 25'd0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_WORK   = 8'h04;
  localparam logic [7:0] REG_PSEL   = 8'h08;
  localparam logic [7:0] REG_PDATA  = 8'h0c;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [3:0] STRB_ALL   = 4'hf;

  typedef enum logic [3:0] {
    S_MEAS, S_PASS, S_ERR, S_MENU, S_EDIT, S_CONF, S_QUICK, S_QNEW
  } kme_state_t;

  typedef enum logic [2:0] {
    DM_MEAS, DM_ERROR, DM_ITEM, DM_VALUE, DM_CONFIRM, DM_LABEL
  } kme_dmode_t;

  typedef struct packed {
    kme_dmode_t  mode;
    kme_val_t    value;
    logic [5:0]  digit_en;
    logic [2:0]  flash;
    logic        flash_en;
  } kme_disp_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic        from_quick;
    logic [2:0]  pos;
    logic [1:0]  item;
    logic        sub;
    logic        level;
    logic [3:0]  state;
  } kme_status_t;

endpackage

/* File: verif/kme_operator.sv */
`timescale 1ns/1ns
// ****************************************
// Front panel operator
// ****************************************
module kme_operator #(
  parameter int TICK_CYC = 10
) (
  input  wire logic       clk,
  output logic      [3:0] btn
);
  initial btn = 4'h0;
  // Clean presses; the pause after release outlasts the debounce window
  task automatic press(input int b, input int ms);
    @(posedge clk);
    btn[b] <= 1'b1;
    repeat (ms * TICK_CYC) @(posedge clk);
    btn[b] <= 1'b0;
    repeat (40 * TICK_CYC) @(posedge clk);
  endtask
endmodule // kme_operator

/* File: verif/test_keypad_menu_editor.sv */
`timescale 1ns/1ns
module test_keypad_menu_editor import kme_pkg::*; ();
  logic        clk;
  logic        rstn;
  wire  [3:0]  btn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid, nv_we;
  logic [1:0]  bresp, rresp, rs;
  logic [3:0]  wstrb;
  kme_disp_t   disp;
  logic [2:0]  nv_addr;
  kme_val_t    nv_data, nv_seen, v0;
  int          errors = 0;
  int          comparisons = 0;
  int          seed = 27154;
  kme_keypad_menu_editor #(.TICK_CYC(1)) kme_keypad_menu_editor_inst (
    .CLK(clk), .RSTN(rstn), .BTN_UP(btn[B_UP]), .BTN_DOWN(btn[B_DN]),
    .BTN_ENTER(btn[B_EN]), .BTN_BACK(btn[B_BK]), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .DISP(disp), .NV_WE(nv_we), .NV_ADDR(nv_addr), .NV_DATA(nv_data));
  kme_operator #(.TICK_CYC(1)) kme_operator_inst (.clk(clk), .btn(btn));
  // ****************************************
  // Bus cycles, checks, expectations
  // ****************************************
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic st(input logic [3:0] e);
    axr(REG_STATUS);
    chk("state", 32'(e), 32'(rd[3:0]));
  endtask
  // Digits kept below nine so one step up never wraps
  function automatic kme_val_t rnd();
    kme_val_t v = PARAM_RST;
    for (int i = 0; i < NDIG; i++) v[i*4+:4] = 4'({$random(seed)} % 9);
    return v;
  endfunction
  function automatic kme_val_t nxt(input kme_val_t v);
    return v + 25'h0100000;
  endfunction
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (nv_we === 1'b1) nv_seen <= nv_data;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (99000) @(posedge clk);
    errors++;
    tally_and_finish;
  end
  initial begin
    {rstn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    wstrb = STRB_ALL;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk("mode", 32'(DM_MEAS), 32'(disp.mode));
    st(S_MEAS);
    v0 = rnd();
    axw(REG_PSEL, 32'(P_THR1));
    axw(REG_PDATA, 32'(v0));
    axr(REG_PDATA);
    chk("pdata", 32'(v0), rd);
    axr(8'h10);
    chk("resp", 32'(RESP_SLVERR), 32'(rs));
    kme_operator_inst.press(B_BK, 1900);
    st(S_MEAS);
    kme_operator_inst.press(B_BK, 2050);
    st(S_MENU);
    chk("mode", 32'(DM_ITEM), 32'(disp.mode));
    kme_operator_inst.press(B_EN, 50);
    st(S_MENU);
    chk("level", 32'h1, 32'(rd[4]));
    kme_operator_inst.press(B_EN, 50);
    st(S_EDIT);
    axr(REG_WORK);
    chk("work", 32'(v0), rd);
    kme_operator_inst.press(B_UP, 50);
    axr(REG_WORK);
    chk("work", 32'(nxt(v0)), rd);
    axr(REG_PDATA);
    chk("pdata", 32'(v0), rd);
    kme_operator_inst.press(B_EN, 2050);
    st(S_CONF);
    kme_operator_inst.press(B_BK, 50);
    st(S_MENU);
    axr(REG_PDATA);
    chk("pdata", 32'(v0), rd);
    kme_operator_inst.press(B_EN, 50);
    kme_operator_inst.press(B_UP, 50);
    kme_operator_inst.press(B_EN, 2050);
    kme_operator_inst.press(B_EN, 50);
    st(S_MENU);
    axr(REG_PDATA);
    chk("pdata", 32'(nxt(v0)), rd);
    chk("nvdata", 32'(nxt(v0)), 32'(nv_seen));
    // One tick per cycle, so millisecond constants count cycles here
    repeat (IDLE_MS - 16'd200) @(posedge clk);
    st(S_MENU);
    repeat (300) @(posedge clk);
    st(S_MEAS);
    kme_operator_inst.press(B_UP, 50);
    st(S_QUICK);
    chk("label", 32'(DM_LABEL), 32'(disp.mode));
    kme_operator_inst.press(B_DN, 50);
    chk("thr", 32'h1, 32'(disp.value));
    kme_operator_inst.press(B_EN, 50);
    st(S_QUICK);
    repeat (QUICK_MS + 16'd100) @(posedge clk);
    st(S_MEAS);
    axw(REG_PSEL, 32'(P_PASS));
    axw(REG_PDATA, 32'h1);
    kme_operator_inst.press(B_BK, 2050);
    st(S_PASS);
    chk("digits", 32'h8, 32'(disp.digit_en));
    repeat (4) kme_operator_inst.press(B_EN, 50);
    st(S_ERR);
    chk("mode", 32'(DM_ERROR), 32'(disp.mode));
    repeat (ERR_MS + 16'd100) @(posedge clk);
    st(S_MEAS);
    kme_operator_inst.press(B_BK, 2050);
    repeat (3) kme_operator_inst.press(B_EN, 50);
    kme_operator_inst.press(B_UP, 50);
    kme_operator_inst.press(B_EN, 50);
    st(S_MENU);
    wstrb <= 4'h1;
    axw(REG_PDATA, 32'h0);
    wstrb <= STRB_ALL;
    axr(REG_PDATA);
    chk("strb", 32'h1, rd);
    tally_and_finish;
  end
endmodule // test_keypad_menu_editor
